/* File: pkg/dsi_pkg.sv */
/*
 * Constants shared by the debug status and identification block.
 * Assumes a 16-bit byte address from the register port and 32-bit data.
 */
package dsi_pkg;

    // Register byte offsets
    localparam logic [15:0] OFS_DEBUG_ADDRESS = 16'h0004;
    localparam logic [15:0] OFS_DCC_ZERO = 16'h0010;
    localparam logic [15:0] OFS_DCC_ONE = 16'h0014;
    localparam logic [15:0] OFS_STATUS_CTRL = 16'h0100;
    localparam logic [15:0] OFS_STATUS_FLAGS = 16'h0104;
    localparam logic [15:0] OFS_PART_LOW = 16'h1FE0;
    localparam logic [15:0] OFS_PID_ONE = 16'h1FE4;

    // Status flag bit positions
    localparam int BIT_PROTECTED = 0;
    localparam int BIT_DBG_PRESENT = 1;
    localparam int BIT_DIRTY_ZERO = 2;
    localparam int BIT_DIRTY_ONE = 3;
    localparam int BIT_HOT_PLUG = 4;

    // Status control bit positions
    localparam int BIT_RESET_EXT = 1;

    // Values after reset
    localparam logic [31:0] RST_DEBUG_ADDRESS = 32'h0000_0000;
    localparam logic [31:0] RST_DCC = 32'h0000_0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // Clock edges on the debug clock that count as an attached probe
    localparam logic [3:0] LINK_EDGES_TO_DETECT = 4'h8;

    // Clock edges after reset release until the strap level is final
    localparam logic [1:0] STRAP_SETTLE_EDGES = 2'h3;

    // Register port decode result
    typedef enum logic [2:0] {
        DSI_SEL_NONE,
        DSI_SEL_ADDR,
        DSI_SEL_DEBUG_COMM_CHANNEL_ZERO,
        DSI_SEL_DEBUG_COMM_CHANNEL_ONE,
        DSI_SEL_CTRL,
        DSI_SEL_FLAGS,
        DSI_SEL_PART,
        DSI_SEL_PID
    } dsi_sel_type;

endpackage

/* File: pkg/dsi_link_if.sv */
/*
 * Carrier between the probe detector on the debug clock and the core logic.
 * Assumes the core synchronises the level before use.
 */
`timescale 1ns/10ps
interface dsi_link_if;
    logic probe_seen;

    modport link (output probe_seen);
    modport core (input probe_seen);
endinterface

/* File: verilog/dsi_link_detect.sv */
/*
 * Probe detector running on the debug clock from the probe.
 * Assumes the debug clock only toggles while a probe drives it.
 */
`timescale 1ns/10ps
module dsi_link_detect
(
    // Link clock and reset
    input wire logic swclk,
    input wire logic rst_b,
    // Towards the core
    dsi_link_if.link lnk
);

    logic rst_meta_q;
    logic rst_sync_q;
    logic [3:0] edge_cnt_q;
    logic seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release aligned to the debug clock
    always_ff @(posedge swclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count clock edges, hold the detect level until reset
    always_ff @(posedge swclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            edge_cnt_q <= 4'h0;
            seen_q <= 1'b0;
        end
        else if (rst_sync_q && !seen_q)
        begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == dsi_pkg::LINK_EDGES_TO_DETECT - 4'h1)
            begin
                seen_q <= 1'b1;
            end
        end
    end

    assign lnk.probe_seen = seen_q;

endmodule

/* File: verilog/dsi_status_ident.sv */
/*
 * Debug service unit status and identification registers.
 * Assumes a same-clock register port with one-cycle read and write strobes,
 * the debug clock from the probe on swclk and a protection strap on a pin.
 */
// Summary of operation
// - Offer reset extension and probe detection
// - Hot-plug flag reads one while enabled
// - Pin function change clears hot-plug; reset only sets
// - Channel write sets dirty, read clears
// - Probe detection sets present flag until reset
// - Protected flag caught at power-up, kept
// - Writes to the flags register never change status flags
// - Part number low returns fixed code
// - Debugger accesses bypass write protection
// - Channel registers never write protected
// - Halted processor disables write protection
`timescale 1ns/10ps
module dsi_status_ident
#(
    // Identification values, arbitrary
    parameter logic [7:0] PART_LOW_CODE = 8'h5A,
    parameter logic [31:0] PID_ONE_CODE = 32'h0000_00A5
)
(
    // Clocks and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic swclk,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_from_dbg,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    // System status
    input wire logic cpu_halted,
    input wire logic guard_lock,
    input wire logic swclk_func_change,
    input wire logic protected_flag_strap,
    // Debug services
    output logic cpu_reset_hold,
    output logic debugger_present,
    output logic hot_plug_enabled
);

    dsi_link_if lnk ();

    logic probe_meta_q;
    logic probe_sync_q;
    logic strap_meta_q;
    logic strap_sync_q;
    logic [1:0] strap_wait_q;
    logic protected_flag_q;
    logic debugger_present_flag_q;
    logic hot_plug_q;
    logic channel_dirty_flag_zero_q;
    logic channel_dirty_flag_one_q;
    logic reset_ext_q;
    logic [31:0] debug_address_q;
    logic [31:0] debug_comm_channel_zero_q;
    logic [31:0] debug_comm_channel_one_q;
    logic [31:0] reg_rdata_q;
    logic [31:0] rdata_d;
    logic reg_ack_q;
    logic reg_err_q;
    logic guard_open;
    logic wr_blocked;

    dsi_pkg::dsi_sel_type sel;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic dsi_pkg::dsi_sel_type decode(input logic [15:0] a);
        dsi_pkg::dsi_sel_type s;
        s = dsi_pkg::DSI_SEL_NONE;
        if (a == dsi_pkg::OFS_DEBUG_ADDRESS)
        begin
            s = dsi_pkg::DSI_SEL_ADDR;
        end
        else if (a == dsi_pkg::OFS_DCC_ZERO)
        begin
            s = dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ZERO;
        end
        else if (a == dsi_pkg::OFS_DCC_ONE)
        begin
            s = dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ONE;
        end
        else if (a == dsi_pkg::OFS_STATUS_CTRL)
        begin
            s = dsi_pkg::DSI_SEL_CTRL;
        end
        else if (a == dsi_pkg::OFS_STATUS_FLAGS)
        begin
            s = dsi_pkg::DSI_SEL_FLAGS;
        end
        else if (a == dsi_pkg::OFS_PART_LOW)
        begin
            s = dsi_pkg::DSI_SEL_PART;
        end
        else if (a == dsi_pkg::OFS_PID_ONE)
        begin
            s = dsi_pkg::DSI_SEL_PID;
        end
        return s;
    endfunction

    assign sel = decode(reg_addr);

    ////////////////////////////////////////////////////////////////////////////
    // Probe detector on the debug clock
    dsi_link_detect u_link
    (
        .swclk (swclk),
        .rst_b (rst_b),
        .lnk (lnk)
    );

    // Detect level into the system clock
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            probe_meta_q <= 1'b0;
            probe_sync_q <= 1'b0;
        end
        else
        begin
            probe_meta_q <= lnk.probe_seen;
            probe_sync_q <= probe_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protection strap, caught once after reset release
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
        end
        else
        begin
            strap_meta_q <= protected_flag_strap;
            strap_sync_q <= strap_meta_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_wait_q <= 2'h0;
            protected_flag_q <= 1'b0;
        end
        else if (strap_wait_q != dsi_pkg::STRAP_SETTLE_EDGES)
        begin
            strap_wait_q <= strap_wait_q + 2'h1;
            protected_flag_q <= strap_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags, changed only by hardware events and channel accesses
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            debugger_present_flag_q <= 1'b0;
        end
        else if (probe_sync_q)
        begin
            debugger_present_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hot_plug_q <= 1'b1;
        end
        else if (swclk_func_change)
        begin
            hot_plug_q <= 1'b0;
        end
    end

    // Set wins over clear when a write and a read meet
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            channel_dirty_flag_zero_q <= 1'b0;
            channel_dirty_flag_one_q <= 1'b0;
        end
        else
        begin
            if (reg_wr && sel == dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ZERO)
            begin
                channel_dirty_flag_zero_q <= 1'b1;
            end
            else if (reg_rd && sel == dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ZERO)
            begin
                channel_dirty_flag_zero_q <= 1'b0;
            end
            if (reg_wr && sel == dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ONE)
            begin
                channel_dirty_flag_one_q <= 1'b1;
            end
            else if (reg_rd && sel == dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ONE)
            begin
                channel_dirty_flag_one_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Processor reset extension, released by writing one
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reset_ext_q <= 1'b1;
        end
        else if (reg_wr && sel == dsi_pkg::DSI_SEL_CTRL && reg_wdata[dsi_pkg::BIT_RESET_EXT])
        begin
            reset_ext_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write protection of the address register
    assign guard_open = !guard_lock || reg_from_dbg || cpu_halted;
    assign wr_blocked = reg_wr && sel == dsi_pkg::DSI_SEL_ADDR && !guard_open;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            debug_address_q <= dsi_pkg::RST_DEBUG_ADDRESS;
        end
        else if (reg_wr && sel == dsi_pkg::DSI_SEL_ADDR && guard_open)
        begin
            debug_address_q <= reg_wdata;
        end
    end

    // Channel registers ignore the guard
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            debug_comm_channel_zero_q <= dsi_pkg::RST_DCC;
            debug_comm_channel_one_q <= dsi_pkg::RST_DCC;
        end
        else
        begin
            if (reg_wr && sel == dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ZERO)
            begin
                debug_comm_channel_zero_q <= reg_wdata;
            end
            if (reg_wr && sel == dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ONE)
            begin
                debug_comm_channel_one_q <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, unused bits zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (sel)
            dsi_pkg::DSI_SEL_ADDR: rdata_d = debug_address_q;
            dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ZERO: rdata_d = debug_comm_channel_zero_q;
            dsi_pkg::DSI_SEL_DEBUG_COMM_CHANNEL_ONE: rdata_d = debug_comm_channel_one_q;
            dsi_pkg::DSI_SEL_CTRL: rdata_d[dsi_pkg::BIT_RESET_EXT] = reset_ext_q;
            dsi_pkg::DSI_SEL_FLAGS:
            begin
                rdata_d[dsi_pkg::BIT_PROTECTED] = protected_flag_q;
                rdata_d[dsi_pkg::BIT_DBG_PRESENT] = debugger_present_flag_q;
                rdata_d[dsi_pkg::BIT_DIRTY_ZERO] = channel_dirty_flag_zero_q;
                rdata_d[dsi_pkg::BIT_DIRTY_ONE] = channel_dirty_flag_one_q;
                rdata_d[dsi_pkg::BIT_HOT_PLUG] = hot_plug_q;
            end
            dsi_pkg::DSI_SEL_PART: rdata_d[7:0] = PART_LOW_CODE;
            dsi_pkg::DSI_SEL_PID: rdata_d = PID_ONE_CODE;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata_q <= dsi_pkg::RST_RDATA;
        end
        else if (reg_rd)
        begin
            reg_rdata_q <= rdata_d;
        end
    end

    // Acknowledge every strobe, flag unmapped or blocked access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_ack_q <= 1'b0;
            reg_err_q <= 1'b0;
        end
        else
        begin
            reg_ack_q <= reg_wr || reg_rd;
            reg_err_q <= ((reg_wr || reg_rd) && sel == dsi_pkg::DSI_SEL_NONE) || wr_blocked;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = reg_rdata_q;
    assign reg_ack = reg_ack_q;
    assign reg_err = reg_err_q;
    assign cpu_reset_hold = reset_ext_q;
    assign debugger_present = debugger_present_flag_q;
    assign hot_plug_enabled = hot_plug_q;

endmodule

/* File: test/dsi_status_checker.sv */
/*
 * Assertions on the ports of the status and identification block.
 * Assumes the clk domain only; bound into dsi_status_ident below.
 */
`timescale 1ns/10ps
module dsi_status_checker
#(
    parameter logic [7:0] PART_LOW_CODE = 8'h5A
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_from_dbg,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    // Status
    input wire logic cpu_halted,
    input wire logic swclk_func_change,
    input wire logic cpu_reset_hold,
    input wire logic debugger_present,
    input wire logic hot_plug_enabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    sequence strobe_s;
        reg_wr || reg_rd;
    endsequence
    sequence addr_wr_s;
        reg_wr && reg_addr == dsi_pkg::OFS_DEBUG_ADDRESS;
    endsequence
    sequence dcc_wr_s;
        reg_wr && (reg_addr == dsi_pkg::OFS_DCC_ZERO || reg_addr == dsi_pkg::OFS_DCC_ONE);
    endsequence
    ////////////////////////////////////////////////////////////////
    ack_follow_a: assert property (strobe_s |=> reg_ack)
        else $error("ack missing after strobe");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 16'h0008 |=> reg_err && reg_rdata == 32'h0)
        else $error("unmapped read not refused");
    part_code_a: assert property (reg_rd && reg_addr == dsi_pkg::OFS_PART_LOW |=> reg_rdata == {24'h0, PART_LOW_CODE})
        else $error("part number wrong");
    dcc_open_a: assert property (dcc_wr_s |=> !reg_err)
        else $error("channel write refused");
    guard_skip_a: assert property (addr_wr_s ##0 (reg_from_dbg || cpu_halted) |=> !reg_err)
        else $error("guard not bypassed");
    present_held_a: assert property (debugger_present |=> debugger_present)
        else $error("present flag dropped");
    hot_clear_a: assert property (swclk_func_change |-> ##[1:3] !hot_plug_enabled)
        else $error("hot plug not cleared");
    hot_stay_a: assert property (!hot_plug_enabled |=> !hot_plug_enabled)
        else $error("hot plug set without reset");
    hold_release_a: assert property (!cpu_reset_hold |=> !cpu_reset_hold)
        else $error("reset hold came back");
    flag_write_a: assert property (reg_wr && reg_addr == dsi_pkg::OFS_STATUS_FLAGS |=> $stable(debugger_present) && $stable(hot_plug_enabled))
        else $error("flag write changed flags");
endmodule

bind dsi_status_ident dsi_status_checker #(.PART_LOW_CODE(PART_LOW_CODE)) u_dsi_status_checker (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_from_dbg(reg_from_dbg), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .cpu_halted(cpu_halted), .swclk_func_change(swclk_func_change),
    .cpu_reset_hold(cpu_reset_hold), .debugger_present(debugger_present),
    .hot_plug_enabled(hot_plug_enabled));

/* File: test/dsi_probe_model.sv */
/*
 * Debugger probe model: drives the debug clock in bursts.
 * Assumes the bench calls attach; the clock stays low between bursts.
 */
`timescale 1ns/10ps
module dsi_probe_model
(
    // Debug clock to the block
    output logic swclk
);
    initial swclk = 1'b0;
    // Burst of rising edges, 64 ns period, off phase with clk
    task automatic attach(input int edges);
        #7;
        repeat (edges)
        begin
            #32 swclk = 1'b1;
            #32 swclk = 1'b0;
        end
    endtask
endmodule

/* File: test/dsi_status_ident_tb_top.sv */
/*
 * Self-checking bench for the status and identification block.
 * Assumes the probe model drives swclk and the checker is bound.
 */
`timescale 1ns/10ps
module dsi_status_ident_tb_top;
    // Identification code, arbitrary
    localparam logic [7:0] PART = 8'h3C;
    localparam logic [31:0] PID = 32'h0000_0069;
    localparam logic [15:0] FL = dsi_pkg::OFS_STATUS_FLAGS;
    localparam logic [15:0] AD = dsi_pkg::OFS_DEBUG_ADDRESS;
    localparam logic [31:0] BASE = 32'h0000_0011;
    logic clk, rst_b, swclk, reg_wr, reg_rd, reg_from_dbg, reg_ack, reg_err;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic cpu_halted, guard_lock, swclk_func_change, protected_flag_strap, er;
    logic cpu_reset_hold, debugger_present, hot_plug_enabled;
    int errors, samples_checked, n;
    ////////////////////////////////////////////////////////////////
    dsi_status_ident #(.PART_LOW_CODE(PART), .PID_ONE_CODE(PID)) u_dsi_status_ident (
        .clk(clk), .rst_b(rst_b), .swclk(swclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_from_dbg(reg_from_dbg),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .cpu_halted(cpu_halted), .guard_lock(guard_lock),
        .swclk_func_change(swclk_func_change), .protected_flag_strap(protected_flag_strap),
        .cpu_reset_hold(cpu_reset_hold), .debugger_present(debugger_present),
        .hot_plug_enabled(hot_plug_enabled));
    dsi_probe_model u_dsi_probe_model (.swclk(swclk));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic dbg);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        reg_from_dbg <= dbg;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
        er = reg_err;
        chk("ack", 32'h1, {31'h0, reg_ack});
    endtask
    task do_reset;
        rst_b <= 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task close_out;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_hold;
        chk("hold", 32'h1, {31'h0, cpu_reset_hold});
        acc(1'b1, dsi_pkg::OFS_STATUS_CTRL, 32'h0000_0002, 1'b0);
        @(posedge clk);
        #1;
        chk("hold", 32'h0, {31'h0, cpu_reset_hold});
    endtask
    task t_ident;
        acc(1'b0, dsi_pkg::OFS_PART_LOW, 32'h0, 1'b0);
        chk("part", {24'h0, PART}, rd);
        acc(1'b1, dsi_pkg::OFS_PART_LOW, 32'hFFFF_FFFF, 1'b0);
        acc(1'b0, dsi_pkg::OFS_PART_LOW, 32'h0, 1'b0);
        chk("part", {24'h0, PART}, rd);
        acc(1'b0, dsi_pkg::OFS_PID_ONE, 32'h0, 1'b0);
        chk("pid", PID, rd);
        acc(1'b0, 16'h0008, 32'h0, 1'b0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask
    task t_flags;
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE, rd);
        acc(1'b1, FL, 32'hFFFF_FFFF, 1'b0);
        acc(1'b1, FL, 32'h0, 1'b0);
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE, rd);
    endtask
    task t_dirty;
        @(posedge clk);
        guard_lock <= 1'b1;
        acc(1'b1, dsi_pkg::OFS_DCC_ZERO, 32'hA5A5_0001, 1'b0);
        chk("dcc err", 32'h0, {31'h0, er});
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE | 32'h4, rd);
        acc(1'b1, dsi_pkg::OFS_DCC_ONE, 32'h5A5A_0002, 1'b0);
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE | 32'hC, rd);
        acc(1'b0, dsi_pkg::OFS_DCC_ZERO, 32'h0, 1'b0);
        chk("debug_comm_channel_zero", 32'hA5A5_0001, rd);
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE | 32'h8, rd);
        acc(1'b0, dsi_pkg::OFS_DCC_ONE, 32'h0, 1'b0);
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE, rd);
    endtask
    task t_guard;
        acc(1'b1, AD, 32'h1111_0000, 1'b0);
        chk("guard err", 32'h1, {31'h0, er});
        acc(1'b0, AD, 32'h0, 1'b0);
        chk("addr", 32'h0, rd);
        acc(1'b1, AD, 32'h2222_0004, 1'b1);
        chk("dbg err", 32'h0, {31'h0, er});
        acc(1'b0, AD, 32'h0, 1'b0);
        chk("addr", 32'h2222_0004, rd);
        @(posedge clk);
        cpu_halted <= 1'b1;
        acc(1'b1, AD, 32'h3333_0008, 1'b0);
        chk("halt err", 32'h0, {31'h0, er});
        acc(1'b0, AD, 32'h0, 1'b0);
        chk("addr", 32'h3333_0008, rd);
        cpu_halted <= 1'b0;
        guard_lock <= 1'b0;
    endtask
    task t_probe;
        chk("present", 32'h0, {31'h0, debugger_present});
        u_dsi_probe_model.attach(12);
        for (n = 0; n < 20 && debugger_present !== 1'b1; n++)
            @(posedge clk);
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE | 32'h2, rd);
    endtask
    task t_hot;
        @(posedge clk);
        swclk_func_change <= 1'b1;
        @(posedge clk);
        swclk_func_change <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("hot", 32'h0, {31'h0, hot_plug_enabled});
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", 32'h3, rd);
        do_reset();
        chk("hot", 32'h1, {31'h0, hot_plug_enabled});
        acc(1'b0, FL, 32'h0, 1'b0);
        chk("flags", BASE, rd);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_b, reg_wr, reg_rd, reg_from_dbg, cpu_halted, guard_lock} = 6'h0;
        {swclk_func_change, reg_addr, reg_wdata} = 49'h0;
        protected_flag_strap = 1'b1;
        errors = 0;
        samples_checked = 0;
        do_reset();
        t_hold();
        t_ident();
        t_flags();
        t_dirty();
        t_guard();
        t_probe();
        t_hot();
        close_out();
    end
    initial
    begin
        #500000;
        errors++;
        close_out();
    end
endmodule
